// ---- fsr_host_model.sv ----
`timescale 1ns/100ps

// Host end of the serial link: mode 0, MSB first, bit period of 160 ns.
module fsr_host_model (
    // Link pins driven by the host.
    output logic      csN,
    output logic      sclk,
    output logic      mosi,
    // Line driven back by the device.
    input  wire logic miso
);
    // The link idles deselected with its clock standing low.
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Sends n bits from the top of d and returns the last 16 bits read.
    task automatic frame(input logic [23:0] d, input int n,
                         output logic [15:0] rx);
        rx = 16'h0;
        #7 csN = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            mosi = d[23-i];
            #80 sclk = 1'b1;
            #40 rx = {rx[14:0], miso};
            #40 sclk = 1'b0;
        end
        #80 csN = 1'b1;
        mosi = ~mosi;
        #200;
    endtask
endmodule

// ---- fsr_map.vh ----
`ifndef FSR_MAP_VH
`define FSR_MAP_VH

// Command opcodes that the status logic decodes itself.
`define FSR_OP_WREN      8'h06
`define FSR_OP_WRDI      8'h04
`define FSR_OP_RDSR      8'h05
`define FSR_OP_WRSR1     8'h01
`define FSR_OP_WRSR2     8'h31
`define FSR_OP_SRST      8'hf0
`define FSR_SRST_CONFIRM 8'hd0

// Field positions of the primary status byte.
`define FSR_S1_LOCK      7
`define FSR_S1_FAIL      5
`define FSR_S1_PIN       4
`define FSR_S1_SUM_HI    3
`define FSR_S1_SUM_LO    2
`define FSR_S1_LATCH     1
`define FSR_BUSY         0

// Field positions of the secondary status byte.
`define FSR_S2_RSTALLOW  4
`define FSR_S2_LDALLOW   3
`define FSR_S2_PSUSP     2
`define FSR_S2_ESUSP     1

// Protection summary encodings.
`define FSR_SUM_NONE     2'h0
`define FSR_SUM_SOME     2'h1
`define FSR_SUM_ALL      2'h3

// Reset values of the stored bits.
`define FSR_RST_LOCK     1'h0
`define FSR_RST_LATCH    1'h0
`define FSR_RST_ALLOW    1'h0

`endif

// ---- fsr_spi_shift.v ----
`timescale 1ns/100ps

// Mode 0 serial shifter: samples on rising clock, drives on falling clock.
module fsr_spi_shift (
    // Clock and reset.
    input  wire       core_clk,
    input  wire       rst_n,
    // Synchronised link pins.
    input  wire       csN,
    input  wire       sclk,
    input  wire       mosi,
    // Byte to send, sampled when each outgoing byte starts.
    input  wire [7:0] txByte,
    // Received bytes and frame status.
    output reg  [7:0] rxByte,
    output reg        rxValid,
    output wire       frameEnd,
    output reg  [2:0] bitCnt,
    output reg        misoOut
);

    reg       sclkPrev;
    reg       csPrev;
    reg [6:0] shiftIn;
    reg [6:0] shiftOut;
    wire      rise;
    wire      fall;

    // Edge detection on the sampled link clock, only inside a frame.
    assign rise     = sclk & ~sclkPrev & ~csN;
    assign fall     = ~sclk & sclkPrev & ~csN;
    assign frameEnd = csN & ~csPrev;

    // Receive path and bit counter.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            sclkPrev <= 1'h0;
            csPrev   <= 1'h1;
            shiftIn  <= 7'h00;
            bitCnt   <= 3'h0;
            rxByte   <= 8'h00;
            rxValid  <= 1'h0;
        end else begin
            sclkPrev <= sclk;
            csPrev   <= csN;
            rxValid  <= 1'h0;
            if (csN) begin
                bitCnt <= 3'h0;
            end else if (rise) begin
                shiftIn <= {shiftIn[5:0], mosi};
                bitCnt  <= bitCnt + 3'h1;
                if (bitCnt == 3'h7) begin
                    rxByte  <= {shiftIn, mosi};
                    rxValid <= 1'h1;
                end
            end
        end
    end

    // Transmit path: a fresh byte is loaded at each byte boundary.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            shiftOut <= 7'h00;
            misoOut  <= 1'h0;
        end else if (fall) begin
            if (bitCnt == 3'h0) begin
                misoOut  <= txByte[7];
                shiftOut <= txByte[6:0];
            end else begin
                misoOut  <= shiftOut[6];
                shiftOut <= {shiftOut[5:0], 1'h0};
            end
        end
    end

endmodule

// ---- fsr_status_ctrl.v ----
`timescale 1ns/100ps
`include "fsr_map.vh"

// Overview of operation
// - Lock bit set blocks sector protect/unprotect and global operations.
// - Lock bit clears at power-up; soft reset leaves it alone.
// - With protect pin asserted, lock bit may only go from 0 to 1.
// - Clearing lock while pin asserted: whole write ignored, latch cleared.
// - Each finished erase/program sets fail flag on error, else clears it.
// - Aborted erase/program never sets the fail flag.
// - Status shows the current level of the write-protect pin.
// - Protection summary is none, some or all, from sector registers.
// - Latch at 0 rejects program, erase, protect, lockdown, status writes.
// - Latch clears at power-up and after soft reset.
// - Latch clears on write disable, gated command end/abort, hold abort, except in the cycle a whole-byte WREN or status-read frame ends.
// - Incomplete or unknown opcode leaves latch unchanged.
// - Reset-allow bit 0 at power-up blocks soft reset; only byte-2 write.
// - Lockdown-allow 0 at power-up blocks lockdown and freeze commands.
// - Lockdown-allow clears on freeze; otherwise only byte-2 write or power cycle.
// - After freeze lockdown, lockdown-allow is held at 0 until the next power-up.
// - Suspend flags show program-suspend and erase-suspend states.
// - Busy reads 1 during internal operation; status refreshes each byte.
// - Opcode 01h, data: lock in bit 7, code in bits 5..2.
// - At frame end a valid write updates lock and clears latch.
// - Write ending off a byte boundary aborts; latch clears.
// - Summary reads 00 none, 01 some, 11 all.
// - First-byte write changes bit 7 of the primary byte and clears the latch in bit 1.
module fsr_status_ctrl (
    // Clock and reset.
    input  wire       core_clk,
    input  wire       rst_n,
    // Serial link pins.
    input  wire       csN,
    input  wire       sclk,
    input  wire       mosi,
    output wire       misoOut,
    output wire       misoOe,
    // Write-protect pin, active low.
    input  wire       wpN,
    // Flash core status, same clock.
    input  wire       coreBusy,
    input  wire       progSuspended,
    input  wire       eraseSuspended,
    input  wire       anySectorProt,
    input  wire       allSectorProt,
    // Flash core events, one-cycle pulses.
    input  wire       opDone,
    input  wire       opError,
    input  wire       gatedCmdEnd,
    input  wire       freezeDone,
    input  wire       holdAbort,
    // Command handoff to the flash core.
    output reg  [7:0] opcode,
    output reg        opcodeValid,
    output wire       protCmdAllowed,
    output wire       gatedCmdAllowed,
    output wire       lockdownCmdAllowed,
    output reg        globalReq,
    output reg  [3:0] globalCode,
    output reg        softResetReq,
    // Stored status bits.
    output reg        writeLatch,
    output reg        protLock,
    output reg        failFlag,
    output reg        resetAllow,
    output reg        lockdownAllow
);

    localparam ST_OPCODE = 3'h0;
    localparam ST_READ   = 3'h1;
    localparam ST_WR1    = 3'h2;
    localparam ST_WR2    = 3'h3;
    localparam ST_RST    = 3'h4;
    localparam ST_OTHER  = 3'h5;

    wire [3:0] pinSync;
    wire       csS;
    wire       sclkS;
    wire       mosiS;
    wire       wpS;
    wire [7:0] rxByte;
    wire       rxValid;
    wire       frameEnd;
    wire [2:0] bitCnt;
    wire       wpAsserted;
    reg  [1:0] summary;
    wire [7:0] status1;
    wire [7:0] status2;
    reg  [2:0] state;
    reg        haveData;
    reg  [7:0] dataByte;
    reg        confirmOk;
    reg        latchAtOp;
    reg        readSecond;
    reg        frozen;

    // All link pins and the protect pin are synchronised first.
    fsr_sync #(
        .W (4)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  ({csN, sclk, mosi, wpN}),
        .syncOut  (pinSync)
    );

    assign csS        = pinSync[3];
    assign sclkS      = pinSync[2];
    assign mosiS      = pinSync[1];
    assign wpS        = pinSync[0];
    assign wpAsserted = ~wpS;

    // Summary of sector protection, 10 never produced.
    always @* begin
        if (allSectorProt) begin
            summary = `FSR_SUM_ALL;
        end else if (anySectorProt) begin
            summary = `FSR_SUM_SOME;
        end else begin
            summary = `FSR_SUM_NONE;
        end
    end

    // Live status bytes; the pin bit reads 0 while the pin is asserted.
    assign status1 = {protLock, 1'h0, failFlag, wpS, summary, writeLatch,
                      coreBusy};
    assign status2 = {3'h0, resetAllow, lockdownAllow, progSuspended,
                      eraseSuspended, coreBusy};

    // Status read alternates primary and secondary, sampled fresh each byte.
    fsr_spi_shift u_shift (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .csN      (csS),
        .sclk     (sclkS),
        .mosi     (mosiS),
        .txByte   (readSecond ? status2 : status1),
        .rxByte   (rxByte),
        .rxValid  (rxValid),
        .frameEnd (frameEnd),
        .bitCnt   (bitCnt),
        .misoOut  (misoOut)
    );

    assign misoOe = ~csS & (state == ST_READ);

    // Permissions handed to the core's command logic.
    assign gatedCmdAllowed    = writeLatch;
    assign protCmdAllowed     = writeLatch & ~protLock;
    assign lockdownCmdAllowed = writeLatch & lockdownAllow
                                & ~frozen;

    // Command sequencer over the bytes of one frame.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state       <= ST_OPCODE;
            opcode      <= 8'h00;
            opcodeValid <= 1'h0;
            haveData    <= 1'h0;
            dataByte    <= 8'h00;
            confirmOk   <= 1'h0;
            latchAtOp   <= 1'h0;
            readSecond  <= 1'h0;
        end else begin
            opcodeValid <= 1'h0;
            if (frameEnd) begin
                state      <= ST_OPCODE;
                haveData   <= 1'h0;
                confirmOk  <= 1'h0;
                readSecond <= 1'h0;
            end else if (rxValid) begin
                case (state)
                    ST_OPCODE: begin
                        opcode      <= rxByte;
                        opcodeValid <= 1'h1;
                        latchAtOp   <= writeLatch;
                        if (rxByte == `FSR_OP_RDSR) begin
                            state <= ST_READ;
                        end else if (rxByte == `FSR_OP_WRSR1) begin
                            state <= ST_WR1;
                        end else if (rxByte == `FSR_OP_WRSR2) begin
                            state <= ST_WR2;
                        end else if (rxByte == `FSR_OP_SRST) begin
                            state <= ST_RST;
                        end else begin
                            state <= ST_OTHER;
                        end
                    end
                    ST_READ: begin
                        readSecond <= ~readSecond;
                    end
                    ST_WR1, ST_WR2: begin
                        if (!haveData) begin
                            dataByte <= rxByte;
                        end
                        haveData <= 1'h1;
                    end
                    ST_RST: begin
                        if (!haveData) begin
                            confirmOk <= (rxByte == `FSR_SRST_CONFIRM);
                        end
                        haveData <= 1'h1;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // Frame-end actions and stored status bits.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            writeLatch    <= `FSR_RST_LATCH;
            protLock      <= `FSR_RST_LOCK;
            failFlag      <= 1'h0;
            resetAllow    <= `FSR_RST_ALLOW;
            lockdownAllow <= `FSR_RST_ALLOW;
            frozen        <= 1'h0;
            globalReq     <= 1'h0;
            globalCode    <= 4'h0;
            softResetReq  <= 1'h0;
        end else begin
            globalReq    <= 1'h0;
            softResetReq <= 1'h0;
            // Only completed operations report; aborts never pulse opDone.
            if (opDone) begin
                failFlag <= opError;
            end
            if (freezeDone) begin
                frozen        <= 1'h1;
                lockdownAllow <= 1'h0;
            end
            if (gatedCmdEnd || holdAbort) begin
                writeLatch <= 1'h0;
            end
            if (frameEnd && bitCnt == 3'h0) begin
                case (state)
                    ST_OPCODE: begin
                        if (opcodeValid) begin
                            writeLatch <= writeLatch;
                        end
                    end
                    ST_WR1: begin
                        writeLatch <= 1'h0;
                        if (haveData && latchAtOp &&
                            !(wpAsserted && protLock &&
                              !dataByte[7])) begin
                            protLock   <= dataByte[7];
                            globalReq  <= ~protLock;
                            globalCode <= dataByte[5:2];
                        end
                    end
                    ST_WR2: begin
                        writeLatch <= 1'h0;
                        if (haveData && latchAtOp) begin
                            resetAllow <= dataByte[`FSR_S2_RSTALLOW];
                            if (!frozen && !freezeDone) begin
                                lockdownAllow <=
                                    dataByte[`FSR_S2_LDALLOW];
                            end
                        end
                    end
                    ST_RST: begin
                        if (haveData && confirmOk && resetAllow) begin
                            softResetReq <= 1'h1;
                            writeLatch   <= 1'h0;
                        end
                    end
                    ST_OTHER: begin
                        if (opcode == `FSR_OP_WRDI) begin
                            writeLatch <= 1'h0;
                        end else if (opcode == `FSR_OP_WREN) begin
                            writeLatch <= 1'h1;
                        end
                    end
                    default: begin
                        writeLatch <= writeLatch;
                    end
                endcase
            end else if (frameEnd &&
                         (state == ST_WR1 || state == ST_WR2)) begin
                writeLatch <= 1'h0;
            end
        end
    end

endmodule

// ---- fsr_status_ctrl_asserts.sv ----
`timescale 1ns/100ps

// Watches the status controller ports for gating and latch hazards.
module fsr_sc_checker (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin and core events.
    input wire logic wpN,
    input wire logic opDone,
    input wire logic opError,
    input wire logic gatedCmdEnd,
    input wire logic holdAbort,
    input wire logic freezeDone,
    // Stored bits and command gates.
    input wire logic protLock,
    input wire logic writeLatch,
    input wire logic failFlag,
    input wire logic resetAllow,
    input wire logic lockdownAllow,
    input wire logic protCmdAllowed,
    input wire logic gatedCmdAllowed,
    input wire logic lockdownCmdAllowed,
    input wire logic softResetReq,
    input wire logic globalReq
);
    logic frozenSeen;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Remembers that a freeze has executed since power-up.
    always @(posedge core_clk) begin
        if (!rst_n) frozenSeen <= 1'b0;
        else if (freezeDone) frozenSeen <= 1'b1;
    end

    a_prot_gate: assert property (
        protCmdAllowed == (writeLatch && !protLock))
        else $error("protect gate wrong");
    a_latch_gate: assert property (
        gatedCmdAllowed == writeLatch) else $error("latch gate wrong");
    a_lockdown_gate: assert property (
        lockdownCmdAllowed |-> writeLatch && lockdownAllow)
        else $error("lockdown gate wrong");
    a_fail_update: assert property (
        opDone |=> failFlag == $past(opError)) else $error("fail not set");
    a_fail_hold: assert property (
        !opDone |=> $stable(failFlag)) else $error("fail moved");
    a_latch_clear: assert property (
        gatedCmdEnd || holdAbort |=> !writeLatch)
        else $error("latch kept");
    a_freeze_hold: assert property (
        frozenSeen |-> !lockdownAllow) else $error("allow after freeze");
    a_lock_pin: assert property (
        $fell(protLock) |-> wpN && $past(wpN, 3))
        else $error("lock cleared while pin asserted");
    a_reset_gate: assert property (
        softResetReq |-> resetAllow) else $error("reset not allowed");
    a_reset_keeps: assert property (
        softResetReq |=> protLock == $past(protLock)
        && lockdownAllow == $past(lockdownAllow))
        else $error("reset changed bits");
    a_reset_latch: assert property (
        softResetReq |-> ##[0:2] !writeLatch) else $error("latch kept");

    cover property (opDone && opError);
    cover property ($fell(protLock));
    cover property (globalReq);
    cover property (softResetReq);
endmodule

bind fsr_status_ctrl fsr_sc_checker i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .wpN(wpN), .opDone(opDone),
    .opError(opError), .gatedCmdEnd(gatedCmdEnd), .holdAbort(holdAbort),
    .freezeDone(freezeDone), .protLock(protLock),
    .writeLatch(writeLatch), .failFlag(failFlag),
    .resetAllow(resetAllow), .lockdownAllow(lockdownAllow),
    .protCmdAllowed(protCmdAllowed), .gatedCmdAllowed(gatedCmdAllowed),
    .lockdownCmdAllowed(lockdownCmdAllowed),
    .softResetReq(softResetReq), .globalReq(globalReq));

// ---- fsr_sync.v ----
`timescale 1ns/100ps

// Two-stage synchroniser for a group of asynchronous pin levels.
module fsr_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         core_clk,
    input  wire         rst_n,
    // Asynchronous inputs and their synchronised copies.
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);

    genvar i;

    // Each bit passes two flops; only the second stage is read.
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    stage1 <= 1'h1;
                    stage2 <= 1'h1;
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate

endmodule

// ---- tb_flash_status_register_control.sv ----
`timescale 1ns/100ps
`include "fsr_map.vh"

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    bad_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb_flash_status_register_control;
    typedef struct {
        logic       wp;
        logic       wren;
        logic [7:0] data;
        int         n;
        logic       lock;
        logic       glob;
    } fsr_row_t;

    // Pin level, write enable, data, bits sent, expected lock and global.
    fsr_row_t rows[8] = '{'{1, 1, 8'h80, 16, 1, 1}, '{0, 1, 8'h00, 16, 1, 0},
        '{0, 1, 8'h80, 16, 1, 0}, '{1, 0, 8'h00, 16, 1, 0},
        '{1, 1, 8'h00, 12, 1, 0}, '{1, 1, 8'h00, 8, 1, 0},
        '{1, 1, 8'h7c, 16, 0, 0}, '{1, 1, 8'h3c, 24, 0, 1}};
    logic [1:0]  sumExp [3] = '{2'h0, 2'h1, 2'h3};
    logic        core_clk, rst_n = 1'b0, csN, sclk, mosi, misoOut, misoOe;
    logic        wpN = 1'b1, coreBusy = 1'b0, progSuspended = 1'b0;
    logic        eraseSuspended = 1'b0, anySectorProt = 1'b0;
    logic        allSectorProt = 1'b0, opError = 1'b0, opDone = 1'b0;
    logic        gatedCmdEnd = 1'b0, freezeDone = 1'b0, holdAbort = 1'b0;
    logic [7:0]  opcode;
    logic [3:0]  globalCode, lastCode;
    logic        opcodeValid, protCmdAllowed, gatedCmdAllowed, globalReq;
    logic        lockdownCmdAllowed, softResetReq, writeLatch, protLock;
    logic        failFlag, resetAllow, lockdownAllow, globHit, srHit, opHit;
    logic [15:0] rxw;
    int          bad_count = 0, total_checks = 0;
    wire         misoLine = misoOe ? misoOut : 1'bz;

    fsr_status_ctrl i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .csN(csN), .sclk(sclk),
        .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe), .wpN(wpN),
        .coreBusy(coreBusy), .progSuspended(progSuspended),
        .eraseSuspended(eraseSuspended), .anySectorProt(anySectorProt),
        .allSectorProt(allSectorProt), .opDone(opDone), .opError(opError),
        .gatedCmdEnd(gatedCmdEnd), .freezeDone(freezeDone),
        .holdAbort(holdAbort), .opcode(opcode), .opcodeValid(opcodeValid),
        .protCmdAllowed(protCmdAllowed), .gatedCmdAllowed(gatedCmdAllowed),
        .lockdownCmdAllowed(lockdownCmdAllowed), .globalReq(globalReq),
        .globalCode(globalCode), .softResetReq(softResetReq),
        .writeLatch(writeLatch), .protLock(protLock), .failFlag(failFlag),
        .resetAllow(resetAllow), .lockdownAllow(lockdownAllow));
    fsr_host_model i_host (.csN(csN), .sclk(sclk), .mosi(mosi),
                           .miso(misoLine));

    // Core clock of 50 MHz.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Records pulses that are too short for the procedures to catch.
    always @(posedge core_clk) begin
        if (globalReq) begin
            globHit <= 1'b1;
            lastCode <= globalCode;
        end
        if (softResetReq) srHit <= 1'b1;
        if (opcodeValid) opHit <= 1'b1;
    end

    task tally_and_finish;
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task tick;
        repeat (3) @(posedge core_clk);
    endtask

    task cmd(input logic [23:0] d, input int n);
        i_host.frame(d, n, rxw);
    endtask

    task wren;
        cmd({`FSR_OP_WREN, 16'h0}, 8);
    endtask

    // Pulses opDone, gatedCmdEnd, holdAbort and freezeDone by mask.
    task pulse(input logic [3:0] m);
        @(posedge core_clk);
        {opDone, gatedCmdEnd, holdAbort, freezeDone} <= m;
        @(posedge core_clk);
        {opDone, gatedCmdEnd, holdAbort, freezeDone} <= 4'h0;
        tick;
    endtask

    // Cuts a hung run short.
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish;
    end

    // Table of first-byte writes, then the awkward cases by hand.
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        `CHK("lock0", 1'b0, protLock)
        `CHK("latch0", 1'b0, writeLatch)
        `CHK("rsta0", 1'b0, resetAllow)
        `CHK("lda0", 1'b0, lockdownAllow)
        foreach (rows[i]) begin
            @(posedge core_clk) wpN <= rows[i].wp;
            tick;
            if (rows[i].wren) wren;
            globHit = 1'b0;
            cmd({`FSR_OP_WRSR1, rows[i].data, 8'h00}, rows[i].n);
            `CHK("lock", rows[i].lock, protLock)
            `CHK("latch", 1'b0, writeLatch)
            `CHK("glob", rows[i].glob, globHit)
            if (rows[i].glob) `CHK("code", rows[i].data[5:2], lastCode)
            cmd({`FSR_OP_RDSR, 16'h0}, 16);
            `CHK("stat", {rows[i].lock, 2'h0, rows[i].wp, 4'h0}, rxw[7:0])
        end
        srHit = 1'b0;
        cmd({`FSR_OP_SRST, `FSR_SRST_CONFIRM, 8'h0}, 16);
        `CHK("srst off", 1'b0, srHit)
        wren;
        cmd({`FSR_OP_WRDI, 16'h0}, 5);
        `CHK("partial", 1'b1, writeLatch)
        opHit = 1'b0;
        cmd(24'h9a0000, 8);
        `CHK("unknown", 1'b1, writeLatch)
        `CHK("opc", 8'h9a, opcode)
        `CHK("opv", 1'b1, opHit)
        cmd({`FSR_OP_WRDI, 16'h0}, 8);
        `CHK("wrdi", 1'b0, writeLatch)
        wren;
        pulse(4'h4);
        `CHK("gend", 1'b0, writeLatch)
        wren;
        pulse(4'h2);
        `CHK("hold", 1'b0, writeLatch)
        @(posedge core_clk) opError <= 1'b1;
        pulse(4'h8);
        `CHK("fail", 1'b1, failFlag)
        cmd({`FSR_OP_RDSR, 16'h0}, 16);
        `CHK("failbit", 1'b1, rxw[5])
        pulse(4'h4);
        `CHK("abort", 1'b1, failFlag)
        @(posedge core_clk) opError <= 1'b0;
        pulse(4'h8);
        `CHK("pass", 1'b0, failFlag)
        wren;
        cmd({`FSR_OP_WRSR2, 8'h18, 8'h0}, 16);
        `CHK("rsta", 1'b1, resetAllow)
        `CHK("lda", 1'b1, lockdownAllow)
        wren;
        cmd({`FSR_OP_WRSR1, 8'h80, 8'h0}, 16);
        wren;
        `CHK("ldgate", 1'b1, lockdownCmdAllowed)
        `CHK("ggate", 1'b1, gatedCmdAllowed)
        `CHK("pgate", 1'b0, protCmdAllowed)
        srHit = 1'b0;
        cmd({`FSR_OP_SRST, `FSR_SRST_CONFIRM, 8'h0}, 16);
        `CHK("srst on", 1'b1, srHit)
        `CHK("srst wl", 1'b0, writeLatch)
        `CHK("srst lk", 1'b1, protLock)
        `CHK("srst ld", 1'b1, lockdownAllow)
        pulse(4'h1);
        `CHK("frz", 1'b0, lockdownAllow)
        wren;
        cmd({`FSR_OP_WRSR2, 8'h18, 8'h0}, 16);
        `CHK("frz2", 1'b0, lockdownAllow)
        @(posedge core_clk);
        coreBusy <= 1'b1;
        progSuspended <= 1'b1;
        fork
            cmd({`FSR_OP_RDSR, 16'h0}, 24);
            begin
                #2000;
                @(posedge core_clk) coreBusy <= 1'b0;
            end
        join
        `CHK("second", 8'h14, rxw[7:0])
        `CHK("poll", 8'h91, rxw[15:8])
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            anySectorProt <= (k != 0);
            allSectorProt <= (k == 2);
            progSuspended <= (k == 0);
            eraseSuspended <= (k == 1);
            tick;
            cmd({`FSR_OP_RDSR, 16'h0}, 24);
            `CHK("sum", sumExp[k], rxw[11:10])
            `CHK("susp", {k == 0, k == 1}, rxw[2:1])
        end
        tally_and_finish;
    end
endmodule
